//--- design/muxed_parallel_mem_port.sv
// Multiplexed address/data parallel port toward an external latch and async memory
// What this block does
// [RL1] Address and data share sixteen lines, core and DMA
// [RL2] Latch strobe marks address versus data phase
// [RL3] External data width selectable: 8 or 16
// [RL4] 8-bit mode: strobe when upper address changes
// [RL5] 8-bit mode: external latch holds upper address bits
// [RL6] Strobe asserted for each new address driven
// [RL7] Strobe active high after reset; polarity selectable
// [RL8] Read strobe low during external reads
// [RL9] Write strobe low during external writes
// [RL10] Flag mode keeps all three strobes inactive
// [RL11] Read/write strobes floating in reset, then high
// [RL12] Shared lines float through and after reset
// [RL13] Address phase precedes data; read/write strobes only in data
`timescale 1ns/1ps
`include "mux_port_consts.svh"
module muxed_parallel_mem_port #(
	parameter int DATA_CYC = `MP_DATA_CYC_DEF
) (
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// Configuration
	input  wire logic        i_mode_16,
	input  wire logic        i_ale_act_low,
	input  wire logic        i_flag_mode,
	// Request from core or DMA
	input  wire logic        i_core_req,
	input  wire logic        i_dma_req,
	input  wire logic        i_req_write,
	input  wire logic [23:0] i_req_addr,
	input  wire logic [15:0] i_req_wdata,
	output logic             o_core_ack,
	output logic             o_dma_ack,
	output logic [15:0]      o_rdata,
	// Shared lines
	input  wire logic [15:0] i_mux_bus_lines,
	output logic [15:0]      o_mux_bus_lines,
	output logic             o_mux_bus_lines_oe,
	// Strobes
	output logic             o_ale,
	output logic             o_rd_n,
	output logic             o_rd_n_oe,
	output logic             o_wr_n,
	output logic             o_wr_n_oe
);
	// Refuse a data phase length outside MP_DATA_CYC_MIN to MP_DATA_CYC_MAX, 3 to 32
	if (DATA_CYC < `MP_DATA_CYC_MIN || DATA_CYC > `MP_DATA_CYC_MAX)
	begin : g_bad_data_cyc
		$error("DATA_CYC out of range");
	end

	// Timer loads; a phase lasts one cycle longer than its load value,
	// so the latch strobe loads one less to stand exactly its own cycle count
	localparam logic [5:0] DCYC  = 6'(DATA_CYC);
	localparam logic [5:0] ALOAD = 6'(`MP_ALE_CYC - 1);

	// Upper sixteen address bits, the part an external latch holds in 8-bit mode
	function automatic logic [15:0] upper_of(input logic [23:0] addr);
		return addr[23:8];
	endfunction : upper_of

	// Active-low strobe level, held inactive while the lines serve as flags
	function automatic logic strobe_level_n(input logic active, input logic flag_mode);
		return !(active && !flag_mode);
	endfunction : strobe_level_n

	mux_port_pkg::port_state_e st_q, st_d;
	logic [15:0] upper_q;       // Upper address last latched externally
	logic        upper_vld_q;
	logic        ale_q, rd_q, wr_q, oe_q, strobe_oe_q;
	logic [15:0] out_q, rdata_q;
	logic        wr_op_q, dma_q, ack_q;
	logic [23:0] addr_q;
	logic [15:0] wdata_q;

	// Arbitration: DMA ahead of core
	wire       req_any   = (i_core_req || i_dma_req) && !i_flag_mode; // [RL10]
	wire       pick_dma  = i_dma_req;
	// First 8-bit access after reset or after a 16-bit access always latches
	wire       upper_chg = !upper_vld_q || (upper_of(i_req_addr) != upper_q);
	// 8-bit mode: skip address phase when upper bits unchanged and low byte only
	wire       need_ale  = i_mode_16 || upper_chg; // [RL4] [RL6]
	wire       t_load;
	wire [5:0] t_cnt;
	wire       t_exp;

	assign t_load = (st_q == mux_port_pkg::ST_IDLE && req_any) || (st_q == mux_port_pkg::ST_HOLD);
	assign t_cnt  = (st_q == mux_port_pkg::ST_IDLE) ? ALOAD : DCYC;

	mux_port_cycle_timer #(.CW(6)) u_timer (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_load    (t_load),
		.i_count   (t_cnt),
		.o_expired (t_exp)
	);

	// Next state
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			mux_port_pkg::ST_IDLE: if (req_any) st_d = need_ale ? mux_port_pkg::ST_ADDR : mux_port_pkg::ST_HOLD;
			mux_port_pkg::ST_ADDR: if (t_exp) st_d = mux_port_pkg::ST_HOLD; // [RL13]
			mux_port_pkg::ST_HOLD: st_d = mux_port_pkg::ST_DATA;
			mux_port_pkg::ST_DATA: if (t_exp) st_d = mux_port_pkg::ST_DONE;
			// One idle turn lets the requester drop its request after the acknowledge
			mux_port_pkg::ST_DONE: st_d = mux_port_pkg::ST_IDLE;
			default:               st_d = mux_port_pkg::ST_IDLE;
		endcase
	end

	// Phase register
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_q <= mux_port_pkg::ST_IDLE;
		else
			st_q <= st_d;
	end

	// Capture request
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			addr_q  <= '0;
			wdata_q <= '0;
			wr_op_q <= 1'b0;
			dma_q   <= 1'b0;
		end
		else if (st_q == mux_port_pkg::ST_IDLE && req_any)
		begin
			addr_q  <= i_req_addr;
			wdata_q <= i_req_wdata;
			wr_op_q <= i_req_write;
			dma_q   <= pick_dma;
		end
	end

	// Upper address tracker for 8-bit mode
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			upper_q     <= '0;
			upper_vld_q <= 1'b0;
		end
		else if (st_q == mux_port_pkg::ST_IDLE && req_any && need_ale)
		begin
			upper_q     <= upper_of(i_req_addr); // [RL5]
			upper_vld_q <= !i_mode_16;
		end
	end

	// Request fields as the next pin update sees them: live while idle, captured after
	wire        wr_op_nx = (st_q == mux_port_pkg::ST_IDLE) ? i_req_write : wr_op_q;
	wire [23:0] a_nx     = (st_q == mux_port_pkg::ST_IDLE) ? i_req_addr : addr_q;
	wire [15:0] w_nx     = (st_q == mux_port_pkg::ST_IDLE) ? i_req_wdata : wdata_q;
	// Shared line contents: address phase then data phase
	wire        in_addr  = (st_d == mux_port_pkg::ST_ADDR);
	wire        in_data  = (st_d == mux_port_pkg::ST_DATA);
	wire        drive    = in_addr || ((st_d == mux_port_pkg::ST_HOLD || in_data) && wr_op_nx);
	// 16-bit mode: address A15-0; 8-bit mode: A23-8 on the lines, A7-0 with data
	wire [15:0] addr_out = i_mode_16 ? a_nx[15:0] : upper_of(a_nx);        // [RL3]
	wire [15:0] data_out = i_mode_16 ? w_nx : {a_nx[7:0], w_nx[7:0]};     // [RL3]

	// Pin registers
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			out_q       <= '0;
			oe_q        <= 1'b0;          // [RL12]
			ale_q       <= 1'b0;
			rd_q        <= 1'b0;
			wr_q        <= 1'b0;
			strobe_oe_q <= 1'b0;          // [RL11]
		end
		else
		begin
			out_q       <= in_addr ? addr_out : data_out; // [RL1]
			oe_q        <= drive && !i_flag_mode;          // [RL1] [RL12]
			ale_q       <= in_addr;                        // [RL2] [RL6]
			rd_q        <= in_data && !wr_op_nx;           // [RL8] [RL13]
			wr_q        <= in_data && wr_op_nx;            // [RL9] [RL13]
			strobe_oe_q <= 1'b1;                           // [RL11]
		end
	end

	// Read data capture at end of the data phase
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rdata_q <= '0;
		else if (st_q == mux_port_pkg::ST_DATA && t_exp && !wr_op_q)
			rdata_q <= i_mode_16 ? i_mux_bus_lines : {8'h00, i_mux_bus_lines[7:0]};
	end

	// Acknowledge pulse, one cycle, raised as the data strobe ends
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			ack_q <= 1'b0;
		else
			ack_q <= (st_q == mux_port_pkg::ST_DATA) && t_exp;
	end

	// Outputs; polarity and flag-mode gating on the strobes
	assign o_mux_bus_lines    = out_q;
	assign o_mux_bus_lines_oe = oe_q;
	assign o_ale              = (ale_q && !i_flag_mode) ^ i_ale_act_low; // [RL7] [RL10]
	assign o_rd_n             = strobe_level_n(rd_q, i_flag_mode);       // [RL10]
	assign o_wr_n             = strobe_level_n(wr_q, i_flag_mode);       // [RL10]
	assign o_rd_n_oe          = strobe_oe_q;
	assign o_wr_n_oe          = strobe_oe_q;
	assign o_rdata            = rdata_q;
	assign o_core_ack         = ack_q && !dma_q;
	assign o_dma_ack          = ack_q && dma_q;
endmodule : muxed_parallel_mem_port

//--- design/mux_port_consts.svh
// Constants for the multiplexed parallel memory port
`ifndef MUX_PORT_CONSTS_SVH
`define MUX_PORT_CONSTS_SVH
`define MP_ADDR_W        24
`define MP_DATA_W        16
`define MP_UPPER_LSB     8
`define MP_CLK_PERIOD_NS 25
`define MP_ALE_NS        25
`define MP_ALE_CYC       (((`MP_ALE_NS) + (`MP_CLK_PERIOD_NS) - 1) / (`MP_CLK_PERIOD_NS))
`define MP_DATA_CYC_MIN  3
`define MP_DATA_CYC_MAX  32
`define MP_DATA_CYC_DEF  3
`endif

//--- design/mux_port_pkg.sv
// Types for the multiplexed parallel memory port
package mux_port_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_HOLD = 3'h3,
		ST_DATA = 3'h2,
		ST_DONE = 3'h6
	} port_state_e;
endpackage : mux_port_pkg

//--- design/mux_port_cycle_timer.sv
// Down counter that times the address and data phases of an external access
`timescale 1ns/1ps
module mux_port_cycle_timer #(
	parameter int CW = 6
) (
	// Clock and reset
	input  wire logic          i_clk_sys,
	input  wire logic          i_rst_n,
	// Control
	input  wire logic          i_load,
	input  wire logic [CW-1:0] i_count,
	// Status
	output logic               o_expired
);
	logic [CW-1:0] cnt_q;

	// Load, then count down to zero
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cnt_q <= '0;
		else if (i_load)
			cnt_q <= i_count;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - CW'(1);
	end

	assign o_expired = (cnt_q == '0) && !i_load;
endmodule : mux_port_cycle_timer

//--- testbench/mux_port_assertions.sv
// Checker for the multiplexed memory port strobes and lines
`timescale 1ns/1ps
module mp_chk (
	input wire logic        i_clk_sys,
	input wire logic        i_rst_n,
	input wire logic        i_mode_16,
	input wire logic        i_ale_act_low,
	input wire logic        i_flag_mode,
	input wire logic        i_req_write,
	input wire logic [23:0] i_req_addr,
	input wire logic [15:0] i_req_wdata,
	input wire logic        o_core_ack,
	input wire logic        o_dma_ack,
	input wire logic [15:0] o_mux_bus_lines,
	input wire logic        o_mux_bus_lines_oe,
	input wire logic        o_ale,
	input wire logic        o_rd_n,
	input wire logic        o_wr_n,
	input wire logic        o_rd_n_oe,
	input wire logic        o_wr_n_oe
);
	// Latch strobe in its active sense
	wire ale_on = o_ale ^ i_ale_act_low;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	property p_rd; $fell(o_rd_n) |-> !i_req_write ##0 !o_rd_n[*4] ##1 o_rd_n; endproperty
	a_rd: assert property (p_rd) else $error("read strobe length");
	property p_wr; $fell(o_wr_n) |-> i_req_write ##0 !o_wr_n[*4] ##1 o_wr_n; endproperty
	a_wr: assert property (p_wr) else $error("write strobe length");
	property p_flag; i_flag_mode |-> o_rd_n && o_wr_n && !ale_on; endproperty
	a_flag: assert property (p_flag) else $error("strobe in flag mode");
	property p_ale1; ale_on |=> !ale_on; endproperty
	a_ale1: assert property (p_ale1) else $error("latch strobe too long");
	property p_aleb; ale_on |-> o_mux_bus_lines_oe && o_mux_bus_lines == (i_mode_16 ? i_req_addr[15:0] : i_req_addr[23:8]); endproperty
	a_aleb: assert property (p_aleb) else $error("address phase wrong");
	property p_wd; !o_wr_n |-> o_mux_bus_lines_oe && o_mux_bus_lines == (i_mode_16 ? i_req_wdata : {i_req_addr[7:0], i_req_wdata[7:0]}); endproperty
	a_wd: assert property (p_wd) else $error("data phase wrong");
	property p_ack; o_core_ack || o_dma_ack |-> $rose(o_rd_n) || $rose(o_wr_n); endproperty
	a_ack: assert property (p_ack) else $error("ack not at strobe end");
	property p_oe; 1 |=> o_rd_n_oe && o_wr_n_oe; endproperty
	a_oe: assert property (p_oe) else $error("strobes not driven");
endmodule : mp_chk
bind muxed_parallel_mem_port mp_chk u_chk (
	.i_clk_sys          (i_clk_sys),
	.i_rst_n            (i_rst_n),
	.i_mode_16          (i_mode_16),
	.i_ale_act_low      (i_ale_act_low),
	.i_flag_mode        (i_flag_mode),
	.i_req_write        (i_req_write),
	.i_req_addr         (i_req_addr),
	.i_req_wdata        (i_req_wdata),
	.o_core_ack         (o_core_ack),
	.o_dma_ack          (o_dma_ack),
	.o_mux_bus_lines    (o_mux_bus_lines),
	.o_mux_bus_lines_oe (o_mux_bus_lines_oe),
	.o_ale              (o_ale),
	.o_rd_n             (o_rd_n),
	.o_wr_n             (o_wr_n),
	.o_rd_n_oe          (o_rd_n_oe),
	.o_wr_n_oe          (o_wr_n_oe)
);

//--- testbench/mem_model.sv
// Behavioural external address latch and async memory
`timescale 1ns/1ps
module mem_model (
	input wire logic        i_clk_sys,
	input wire logic        i_mode_16,
	input wire logic        i_ale_on,
	input wire logic        i_rd_n,
	input wire logic        i_wr_n,
	input wire logic [15:0] i_lines,
	output logic            o_drv,
	output logic [15:0]     o_data
);
	logic [15:0] mem [int];
	logic [15:0] a_q = 16'h0;
	// Address capture on strobe, data stored while write strobe low
	always @(posedge i_clk_sys)
	begin
		if (i_ale_on) a_q <= i_lines;
		if (!i_wr_n && i_mode_16) mem[int'(a_q)] = i_lines;
		if (!i_wr_n && !i_mode_16) mem[int'({a_q, i_lines[15:8]})] = {8'h00, i_lines[7:0]};
		o_data <= mem.exists(int'(a_q)) ? mem[int'(a_q)] : ~a_q;
	end
	assign o_drv = !i_rd_n;
endmodule : mem_model

//--- testbench/tb_muxed_parallel_mem_port.sv
// Self-checking bench for the multiplexed memory port
`timescale 1ns/1ps
module tb_muxed_parallel_mem_port;
	logic i_clk_sys = 0, i_rst_n = 0, i_mode_16 = 1, i_ale_act_low = 0, i_flag_mode = 0;
	logic i_core_req = 0, i_dma_req = 0, i_req_write = 0, o_core_ack, o_dma_ack, m_drv;
	logic o_mux_bus_lines_oe, o_ale, o_rd_n, o_rd_n_oe, o_wr_n, o_wr_n_oe;
	logic [23:0] i_req_addr = 0;
	logic [15:0] i_req_wdata = 0, i_mux_bus_lines, o_mux_bus_lines, o_rdata, m_data, lf = 16'hab27;
	logic [17:0] e, q [$];
	logic [15:0] mirror [int];
	int n_mismatch = 0, checked = 0, n_ale = 0, n_ack = 0, s;
	muxed_parallel_mem_port dut (
		.i_clk_sys          (i_clk_sys),
		.i_rst_n            (i_rst_n),
		.i_mode_16          (i_mode_16),
		.i_ale_act_low      (i_ale_act_low),
		.i_flag_mode        (i_flag_mode),
		.i_core_req         (i_core_req),
		.i_dma_req          (i_dma_req),
		.i_req_write        (i_req_write),
		.i_req_addr         (i_req_addr),
		.i_req_wdata        (i_req_wdata),
		.o_core_ack         (o_core_ack),
		.o_dma_ack          (o_dma_ack),
		.o_rdata            (o_rdata),
		.i_mux_bus_lines    (i_mux_bus_lines),
		.o_mux_bus_lines    (o_mux_bus_lines),
		.o_mux_bus_lines_oe (o_mux_bus_lines_oe),
		.o_ale              (o_ale),
		.o_rd_n             (o_rd_n),
		.o_rd_n_oe          (o_rd_n_oe),
		.o_wr_n             (o_wr_n),
		.o_wr_n_oe          (o_wr_n_oe)
	);
	mem_model u_mem (.i_clk_sys(i_clk_sys), .i_mode_16(i_mode_16), .i_ale_on(o_ale ^ i_ale_act_low),
		.i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_lines(o_mux_bus_lines), .o_drv(m_drv), .o_data(m_data));
	// Wire level: device, then memory, else pull-ups
	assign i_mux_bus_lines = o_mux_bus_lines_oe ? o_mux_bus_lines : m_drv ? m_data : 16'hffff;
	initial forever #12.5 i_clk_sys = ~i_clk_sys;
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nxt
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin n_mismatch++; $display("ERROR %0t got %h exp %h", $time, got, exp); end
	endtask : chk
	// One access held until acknowledged, expectation noted first
	task automatic acc(input logic dma, input logic wr, input logic [23:0] a, input logic [15:0] d);
		int t = 0;
		q.push_back({wr, dma, wr ? 16'h0 : mirror[int'(a)]});
		if (wr) mirror[int'(a)] = d;
		i_dma_req <= dma;
		i_core_req <= !dma;
		i_req_write <= wr;
		i_req_addr <= a;
		i_req_wdata <= d;
		while (o_core_ack !== 1'b1 && o_dma_ack !== 1'b1 && t < 50) begin @(posedge i_clk_sys); #2; t++; end
		chk(16'(t < 50), 16'h1);
		i_dma_req <= 0;
		i_core_req <= 0;
		@(posedge i_clk_sys) #2;
	endtask : acc
	// Takes the oldest note at each acknowledge
	always @(posedge i_clk_sys)
	begin
		if (o_ale ^ i_ale_act_low) n_ale++;
		if (o_core_ack === 1'b1 || o_dma_ack === 1'b1) begin
			n_ack++;
			e = q.pop_front();
			chk(16'(o_dma_ack), 16'(e[16]));
			if (!e[17]) chk(o_rdata, e[15:0]);
		end
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	initial begin #(25 * 3000); n_mismatch++; end_sim; end
	initial
	begin
		repeat (5) @(posedge i_clk_sys);
		#2;
		chk({13'h0, o_mux_bus_lines_oe, o_rd_n_oe, o_wr_n_oe}, 16'h0);
		i_rst_n <= 1;
		@(posedge i_clk_sys) #2;
		chk({10'h0, o_mux_bus_lines_oe, o_ale, o_rd_n_oe, o_wr_n_oe, o_rd_n, o_wr_n}, 16'h000f);
		for (int k = 0; k < 8; k++) begin lf = nxt(lf); acc(k[0], 1, {8'h0, lf}, ~lf); acc(!k[0], 0, {8'h0, lf}, 0); end
		$display("16-bit traffic done");
		i_mode_16 <= 0;
		for (int k = 0; k < 4; k++) begin
			i_ale_act_low <= k[1];
			s = n_ale;
			lf = nxt(lf);
			acc(0, 1, {16'h1200 + 16'(k / 2), lf[7:0]}, ~lf);
			chk(16'(n_ale - s), 16'(!k[0]));
			chk(u_mem.mem[int'({16'h1200 + 16'(k / 2), lf[7:0]})], {8'h0, ~lf[7:0]});
		end
		$display("8-bit traffic done");
		i_ale_act_low <= 0;
		i_flag_mode <= 1;
		i_core_req <= 1;
		s = n_ack;
		repeat (20) @(posedge i_clk_sys);
		chk(16'(n_ack - s), 16'h0);
		$display("flag mode done");
		end_sim;
	end
endmodule : tb_muxed_parallel_mem_port
